// File: include/acr_pkg.sv
/*
 * acr_pkg: constants and carrier types for the adc channel configuration
 * register pair. Assumes an 8-bit register address space on the control port.
 */
package acr_pkg;
   localparam int          ACR_SAMPLE_W       = 24;
   localparam int          ACR_DELAY_MAX      = 63;
   localparam logic [7:0]  ACR_OFS_CH1_PHASE  = 8'h54;
   localparam logic [7:0]  ACR_OFS_CH2_INPUT  = 8'h55;
   localparam logic [7:0]  ACR_RST_CH1_PHASE  = 8'h00;
   localparam logic [7:0]  ACR_RST_CH2_INPUT  = 8'h00;
   localparam logic [7:0]  ACR_RD_UNMAPPED    = 8'h00;
   localparam logic [1:0]  ACR_RSVD_VALUE     = 2'h0;
   // ch1 phase register field positions
   localparam int          ACR_PH_DELAY_LSB   = 2;
   localparam int          ACR_PH_PATH_LSB    = 0;
   // ch2 input register field positions
   localparam int          ACR_IN_SRC_LSB     = 6;
   localparam int          ACR_IN_RSVD_LSB    = 4;
   localparam int          ACR_IN_CMTOL_LSB   = 2;
   localparam int          ACR_IN_FS_BIT      = 1;
   localparam int          ACR_IN_BW_BIT      = 0;
   // path select codes
   localparam logic [1:0]  ACR_PATH_BOTH      = 2'h0;
   localparam logic [1:0]  ACR_PATH_ANALOG    = 2'h1;
   localparam logic [1:0]  ACR_PATH_DIGITAL   = 2'h2;

   typedef struct packed {
      logic [5:0] delay;
      logic [1:0] path;
   } acr_ch1_phase_t;

   typedef struct packed {
      logic [1:0] input_source;
      logic [1:0] common_mode_tolerance;
      logic       full_scale_select;
      logic       bandwidth_select;
   } acr_ch2_input_t;
endpackage

// File: hw/acr_adc_channel_config_regs.sv
/*
 * acr_adc_channel_config_regs: ch1 phase calibration register with its
 * digital sample delay line, and the ch2 input configuration register.
 * Assumes clk is the modulator clock and that the control-port decoder
 * presents byte register accesses on the same clock.
 */
// What this block does
// - Channel 1 samples are delayed by N modulator cycles, N being bits 7..2 from 0 to 63.
// - Path select bits 1..0 apply the delay to both paths at 0, analog at 1, digital at 2.
// - The ch1 phase register sits at 0x54 and resets to 0x00.
// - Ch2 bits 7..6 pick differential at 0, single-ended at 1; software avoids 2 and 3.
// - Ch2 bits 5..4 are read-only zero and software writes only zero there.
// - Ch2 bits 3..2 pick narrow AC, moderate AC/DC or rail-to-rail tolerance.
// - Ch2 bit 1 picks 10 Vrms full scale when clear and 5 Vrms when set.
// - Ch2 bit 0 picks 24 kHz when clear and 96 kHz when set, wide only at 40 kohm.
// - The ch2 input register sits at 0x55 and resets to 0x00.
`timescale 1ns/1ps
module acr_adc_channel_config_regs
   import acr_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   // channel 1 datapath
   input  wire logic [ACR_SAMPLE_W-1:0] ch1_sample_in,
   output logic      [ACR_SAMPLE_W-1:0] ch1_sample_out,
   output logic      [5:0]              ch1_analog_delay,
   // channel 2 front-end controls
   output acr_ch2_input_t               ch2_cfg
);

   acr_ch1_phase_t            ch1_phase;
   logic [ACR_SAMPLE_W-1:0]   line [ACR_DELAY_MAX];
   logic [7:0]                next_rdata;
   logic [ACR_SAMPLE_W-1:0]   next_sample;

   // one address compare shared by both register decodes
   function automatic logic acr_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   wire       hit_phase = acr_hit(reg_addr, ACR_OFS_CH1_PHASE);
   wire       hit_input = acr_hit(reg_addr, ACR_OFS_CH2_INPUT);
   wire       dig_on    = ch1_phase.path != ACR_PATH_ANALOG;
   wire       ana_on    = ch1_phase.path == ACR_PATH_BOTH ||
                          ch1_phase.path == ACR_PATH_ANALOG;
   // reserved path code 3 behaves as digital-only: no analog delay is driven
   wire [7:0] ch2_view  = {ch2_cfg.input_source, ACR_RSVD_VALUE,
                           ch2_cfg.common_mode_tolerance,
                           ch2_cfg.full_scale_select, ch2_cfg.bandwidth_select};

   assign next_rdata  = hit_phase ? ch1_phase :
                        hit_input ? ch2_view  : ACR_RD_UNMAPPED;
   // line[k] holds the input from k+1 cycles back; a zero delay is a straight pass
   assign next_sample = (!dig_on || ch1_phase.delay == 6'h00) ? ch1_sample_in
                        : line[ch1_phase.delay - 6'h01];

   // reserved codes are stored as written, no error path exists
   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_phase <= ACR_RST_CH1_PHASE;
      end else if (reg_wr && hit_phase) begin
         ch1_phase <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ch2_cfg <= ACR_RST_CH2_INPUT[7:2];
      end else if (reg_wr && hit_input) begin
         // reserved bits 5..4 are dropped; stored fields steer the front end
         ch2_cfg <= {reg_wdata[7:6], reg_wdata[3:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // the line keeps shifting under any setting so a new delay takes effect at once
   always_ff @(posedge clk) begin
      line[0] <= ch1_sample_in;
      for (int k = 1; k < ACR_DELAY_MAX; k++) begin
         line[k] <= line[k-1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ch1_sample_out   <= '0;
         ch1_analog_delay <= 6'h00;
      end else begin
         ch1_sample_out   <= next_sample;
         ch1_analog_delay <= ana_on ? ch1_phase.delay : 6'h00;
      end
   end

   sequence s_phase_write(logic [7:0] v);
      reg_wr && hit_phase && reg_wdata == v;
   endsequence

   sequence s_input_read;
      reg_rd && !reg_wr && hit_input;
   endsequence

   sequence s_phase_read;
      reg_rd && !reg_wr && hit_phase;
   endsequence

   property p_delay_zero;
      @(posedge clk) disable iff (rst)
      (ch1_phase == 8'h00) |=> (ch1_sample_out == $past(ch1_sample_in));
   endproperty
   a_delay_zero: assert property (p_delay_zero) else $error("zero delay not a pass");

   property p_delay_three;
      @(posedge clk) disable iff (rst)
      (ch1_phase.delay == 6'h03 && ch1_phase.path == ACR_PATH_DIGITAL)
         |=> (ch1_sample_out == $past(ch1_sample_in, 4));
   endproperty
   a_delay_three: assert property (p_delay_three) else $error("delay of 3 wrong");

   property p_analog_only;
      @(posedge clk) disable iff (rst)
      (ch1_phase.path == ACR_PATH_ANALOG)
         |=> (ch1_sample_out == $past(ch1_sample_in) &&
              ch1_analog_delay == $past(ch1_phase.delay));
   endproperty
   a_analog_only: assert property (p_analog_only) else $error("analog-only path wrong");

   property p_digital_only;
      @(posedge clk) disable iff (rst)
      (ch1_phase.path == ACR_PATH_DIGITAL) |=> ch1_analog_delay == 6'h00;
   endproperty
   a_digital_only: assert property (p_digital_only) else $error("analog delay leaked");

   property p_phase_reset;
      @(posedge clk) rst |=> (ch1_phase == ACR_RST_CH1_PHASE && ch1_analog_delay == 6'h00);
   endproperty
   a_phase_reset: assert property (p_phase_reset) else $error("phase reset wrong");

   property p_input_write;
      @(posedge clk) disable iff (rst)
      (reg_wr && hit_input) |=> (ch2_cfg.input_source == $past(reg_wdata[7:6]) &&
         ch2_cfg.common_mode_tolerance == $past(reg_wdata[3:2]));
   endproperty
   a_input_write: assert property (p_input_write) else $error("ch2 fields not stored");

   property p_rsvd_zero;
      @(posedge clk) disable iff (rst)
      s_input_read |=> reg_rdata[5:4] == 2'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

   property p_cmtol_hold;
      @(posedge clk) disable iff (rst)
      !(reg_wr && hit_input) |=> $stable(ch2_cfg.common_mode_tolerance);
   endproperty
   a_cmtol_hold: assert property (p_cmtol_hold) else $error("tolerance changed");

   property p_fs_bw;
      @(posedge clk) disable iff (rst)
      (reg_wr && hit_input) ##1 s_input_read
         |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2);
   endproperty
   a_fs_bw: assert property (p_fs_bw) else $error("scale or bandwidth lost");

   property p_bw_drive;
      @(posedge clk) disable iff (rst)
      (reg_wr && hit_input) |=> ch2_cfg.bandwidth_select == $past(reg_wdata[0]);
   endproperty
   a_bw_drive: assert property (p_bw_drive) else $error("bandwidth not driven");

   property p_input_reset;
      @(posedge clk) rst |=> ch2_cfg == 6'h00;
   endproperty
   a_input_reset: assert property (p_input_reset) else $error("ch2 reset wrong");

   property p_rsvd_code;
      @(posedge clk) disable iff (rst)
      s_phase_write(8'h03) ##1 (reg_rd && !reg_wr && hit_phase) |=> reg_rdata == 8'h03;
   endproperty
   a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code lost");

   property p_phase_readback;
      @(posedge clk) disable iff (rst)
      (reg_wr && hit_phase) ##1 s_phase_read |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_phase_readback: assert property (p_phase_readback) else $error("readback lost");

   property p_analog_both;
      @(posedge clk) disable iff (rst)
      (ch1_phase.path == ACR_PATH_BOTH) |=> ch1_analog_delay == $past(ch1_phase.delay);
   endproperty
   a_analog_both: assert property (p_analog_both) else $error("both-path delay wrong");

   // longest setting: the full line plus the output register
   property p_delay_max;
      @(posedge clk) disable iff (rst)
      (ch1_phase.delay == 6'h3f && ch1_phase.path == ACR_PATH_BOTH)
         |=> ch1_sample_out == $past(ch1_sample_in, 64);
   endproperty
   a_delay_max: assert property (p_delay_max) else $error("delay of 63 wrong");

   property p_fs_drive;
      @(posedge clk) disable iff (rst)
      (reg_wr && hit_input) |=> ch2_cfg.full_scale_select == $past(reg_wdata[1]);
   endproperty
   a_fs_drive: assert property (p_fs_drive) else $error("full scale not driven");

   property p_fs_hold;
      @(posedge clk) disable iff (rst)
      !(reg_wr && hit_input) |=> $stable(ch2_cfg.full_scale_select);
   endproperty
   a_fs_hold: assert property (p_fs_hold) else $error("full scale changed");

endmodule

// File: sim/tb.sv
/*
 * tb: self-checking bench for the adc channel config register pair.
 * Assumes the byte register port and the 1-cycle read and write latencies of the design.
 */
`timescale 1ns/1ps
module tb;
   import acr_pkg::*;
   logic                    clk, rst, reg_wr, reg_rd;
   logic [7:0]              reg_addr, reg_wdata, reg_rdata;
   logic [ACR_SAMPLE_W-1:0] ch1_sample_in, ch1_sample_out;
   logic [5:0]              ch1_analog_delay;
   acr_ch2_input_t          ch2_cfg;
   int                      bad_count, samples_checked;

   acr_adc_channel_config_regs DUT (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_sample_in(ch1_sample_in),
      .ch1_sample_out(ch1_sample_out), .ch1_analog_delay(ch1_analog_delay), .ch2_cfg(ch2_cfg));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // a ramp makes any delay visible as a plain difference
   always @(posedge clk) ch1_sample_in <= #1 ch1_sample_in + 24'h1;

   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      chk("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
   endtask
   // write then read the same register on the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      chk("reg_rdata", {16'h0, d}, {16'h0, reg_rdata});
   endtask
   // the line never stops shifting, so nothing needs flushing; the wait still runs past the longest delay
   task automatic samp(input logic [5:0] n, input logic [1:0] p, input int d, input logic [5:0] a);
      wr(ACR_OFS_CH1_PHASE, {n, p});
      repeat (66) @(posedge clk);
      #2 chk("sample_out", ch1_sample_in - 24'(d), ch1_sample_out);
      chk("analog_delay", {18'h0, a}, {18'h0, ch1_analog_delay});
      rd(ACR_OFS_CH1_PHASE, {n, p});
   endtask

   task automatic t_reset;
      chk("ch2_cfg", 24'h0, {18'h0, ch2_cfg});
      chk("analog_delay", 24'h0, {18'h0, ch1_analog_delay});
      rd(ACR_OFS_CH1_PHASE, 8'h00);
      rd(ACR_OFS_CH2_INPUT, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_ch2;
      wr(ACR_OFS_CH2_INPUT, 8'h4f);
      chk("ch2_cfg", 24'h1f, {18'h0, ch2_cfg});
      rd(ACR_OFS_CH2_INPUT, 8'h4f);
      wr(ACR_OFS_CH2_INPUT, 8'h46);
      chk("ch2_cfg", 24'h16, {18'h0, ch2_cfg});
      wr(ACR_OFS_CH2_INPUT, 8'h09);
      chk("ch2_cfg", 24'h09, {18'h0, ch2_cfg});
      wr(8'h56, 8'haa);
      rd(8'h56, ACR_RD_UNMAPPED);
      rd(ACR_OFS_CH2_INPUT, 8'h09);
      $display("test ch2 done");
   endtask
   task automatic t_b2b;
      wr_rd(ACR_OFS_CH1_PHASE, 8'h03);
      chk("analog_delay", 24'h0, {18'h0, ch1_analog_delay});
      wr_rd(ACR_OFS_CH2_INPUT, 8'h42);
      chk("ch2_cfg", 24'h12, {18'h0, ch2_cfg});
      $display("test back to back done");
   endtask
   task automatic t_midreset;
      wr(ACR_OFS_CH1_PHASE, 8'h29);
      @(posedge clk);
      #1 chk("analog_delay", 24'ha, {18'h0, ch1_analog_delay});
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      t_reset;
      $display("test mid-run reset done");
   endtask
   task automatic t_ch1;
      samp(6'd3, ACR_PATH_DIGITAL, 4, 6'd0);
      samp(6'd3, ACR_PATH_ANALOG, 1, 6'd3);
      samp(6'd63, ACR_PATH_BOTH, 64, 6'd63);
      samp(6'd0, ACR_PATH_BOTH, 1, 6'd0);
      samp(6'd5, 2'h3, 6, 6'd0);
      $display("test ch1 done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      ch1_sample_in = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      t_reset;
      t_ch2;
      t_ch1;
      t_b2b;
      t_midreset;
      finish_test;
   end
   initial begin
      #(25 * 2000);
      bad_count++;
      finish_test;
   end
endmodule
